// File: hdl/btp_pkg.sv
package btp_pkg;
  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int N_CH = 4;
  localparam int N_UNIT = 2;
  localparam int CNT_W = 8;
  localparam logic [7:0] OFS_START = 8'h40;
  localparam logic [7:0] OFS_STOP = 8'h44;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CMPA = 4'h4;
  localparam logic [3:0] OFS_CMPB = 4'h8;
  localparam logic [3:0] OFS_CNT = 4'hC;
  // ------------------------------------------------------------
  // channel control fields
  // ------------------------------------------------------------
  localparam int CTRL_W = 11;
  localparam int CKS_LSB = 0;
  localparam int CLR_LSB = 3;
  localparam int OUT_LSB = 5;
  localparam int EVT_LSB = 7;
  localparam int CASC_LSB = 9;
  localparam logic [2:0] CKS_EXT = 3'h7;
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_EXT = 2'h3;
  localparam logic [1:0] OUT_TGL_A = 2'h1;
  localparam logic [1:0] OUT_PWM = 2'h2;
  localparam logic [1:0] OUT_TGL_B = 2'h3;
  localparam logic [1:0] EVT_START = 2'h1;
  localparam logic [1:0] EVT_COUNT = 2'h2;
  localparam logic [1:0] EVT_RESTART = 2'h3;
  localparam logic [1:0] CASC_16 = 2'h1;
  localparam logic [1:0] CASC_CMC = 2'h2;
  // ------------------------------------------------------------
  // reset values, prescaler and baud sources
  // ------------------------------------------------------------
  localparam logic [CTRL_W-1:0] RST_CTRL = 11'h000;
  localparam logic [7:0] RST_CMP = 8'hFF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int PSC_W = 13;
  localparam logic [PSC_W-1:0] DIV_MASK [7] = '{13'h0000, 13'h0001, 13'h0007,
    13'h001F, 13'h003F, 13'h03FF, 13'h1FFF};
  localparam int BAUD5_CH = 1;
  localparam int BAUD6_CH = 3;
  localparam int BAUD12_CH = 2;
endpackage : btp_pkg

// File: hdl/btp_byte_timer.sv
// Behaviour
// (R1) internal count clock: peripheral clock divided by 1,2,8,32,64,1024,8192
// (R2) a channel may count edges of its external count clock instead
// (R3) two units of two channels, each with an 8-bit counter
// (R4) compare matches A and B per channel, or per cascaded 16-bit pair
// (R5) counter clear source: match A, match B or external reset
// (R6) each channel drives a timer output: toggle or PWM from matches
// (R7) 16-bit mode: even channel is upper byte, odd channel lower byte
// (R8) compare match count mode: odd channel counts even channel's matches
// (R9) interrupt requests for match A, match B and overflow per channel
// (R10) match A, match B and overflow of all channels go out as events
// (R11) input event starts, clocks or restarts the channel as configured
// (R12) match A and match B requests can activate the transfer controller
// (R13) match A of each unit's first channel triggers the A/D converter
// (R14) baud clocks for serial channels five, six and twelve
// (R15) each unit can be stopped by its module-stop bit
// (R16) a writable counter start register starts and stops channels
// (R17) each count edge adds one; wrap from maximum to zero flags overflow
// (R18) a match is flagged in the count cycle when counter equals constant
`timescale 1ns/1ns
module btp_byte_timer (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [btp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] ext_clk,
  input wire logic [3:0] ext_rst,
  input wire logic [3:0] evt_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [3:0] tmo,
  output logic [3:0] irq_cma,
  output logic [3:0] irq_cmb,
  output logic [3:0] irq_ovf,
  output logic [3:0] evt_cma,
  output logic [3:0] evt_cmb,
  output logic [3:0] evt_ovf,
  output logic [3:0] dtc_req,
  output logic [1:0] adc_trig,
  output logic [2:0] baud_clk
);
  logic [btp_pkg::PSC_W-1:0] psc_q;
  logic [7:0] tick;
  logic [btp_pkg::CTRL_W-1:0] ctrl_q [4];
  logic [7:0] cmpa_q [4];
  logic [7:0] cmpb_q [4];
  logic [7:0] cnt_q [4];
  logic [3:0] start_q;
  logic [1:0] stop_q;
  logic [3:0] xc_s1_q, xc_s2_q, xc_s3_q;
  logic [3:0] xr_s1_q, xr_s2_q, xr_s3_q;
  logic [3:0] xc_edge, xr_edge, run, own_edge, edge_c, ma, mb, ovf, clr, evt_rst, evt_set;
  logic [3:0] start_d;
  logic in_ch, hit, wr_en;
  logic [1:0] ch_sel;
  logic [31:0] rdata;

  // ------------------------------------------------------------
  // prescaler and pin synchronisers
  // ------------------------------------------------------------
  // free running divider; a tap fires when its low bits are all ones
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      psc_q <= '0;
    end else begin
      psc_q <= psc_q + 13'h0001;
    end
  end

  // one tick per divide ratio, index equals clock select code
  always_comb begin
    tick = 8'h00;
    for (int k = 0; k < 7; k++) begin
      tick[k] = (psc_q & btp_pkg::DIV_MASK[k]) == btp_pkg::DIV_MASK[k]; // [R1]
    end
  end

  // pins are asynchronous: two flops, then a third only for edge detect
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      xc_s1_q <= 4'h0;
      xc_s2_q <= 4'h0;
      xc_s3_q <= 4'h0;
      xr_s1_q <= 4'h0;
      xr_s2_q <= 4'h0;
      xr_s3_q <= 4'h0;
    end else begin
      xc_s1_q <= ext_clk;
      xc_s2_q <= xc_s1_q;
      xc_s3_q <= xc_s2_q;
      xr_s1_q <= ext_rst;
      xr_s2_q <= xr_s1_q;
      xr_s3_q <= xr_s2_q;
    end
  end

  assign xc_edge = xc_s2_q & ~xc_s3_q;
  assign xr_edge = xr_s2_q & ~xr_s3_q;

  // ------------------------------------------------------------
  // channel datapath
  // ------------------------------------------------------------
  function automatic logic clr_f(logic [1:0] s, logic a, logic b, logic x);
    return (s == btp_pkg::CLR_A && a) || (s == btp_pkg::CLR_B && b)
      || (s == btp_pkg::CLR_EXT && x); // [R5]
  endfunction : clr_f

  // even channel is computed from its own clock first, so the odd channel
  // can consume its matches without a combinational loop through the pair
  always_comb begin
    logic [1:0] cs;
    logic [15:0] c16;
    logic m8a, m8b;
    cs = 2'h0;
    c16 = 16'h0000;
    m8a = 1'b0;
    m8b = 1'b0;
    for (int i = 0; i < btp_pkg::N_CH; i++) begin
      run[i] = start_q[i] & ~stop_q[i/2]; // [R15] [R16]
      evt_set[i] = evt_in[i] & (ctrl_q[i][btp_pkg::EVT_LSB+:2] == btp_pkg::EVT_START
        || ctrl_q[i][btp_pkg::EVT_LSB+:2] == btp_pkg::EVT_RESTART); // [R11]
      evt_rst[i] = evt_in[i] & (ctrl_q[i][btp_pkg::EVT_LSB+:2] == btp_pkg::EVT_RESTART);
      if (ctrl_q[i][btp_pkg::EVT_LSB+:2] == btp_pkg::EVT_COUNT) begin
        own_edge[i] = run[i] & evt_in[i]; // [R11]
      end else if (ctrl_q[i][btp_pkg::CKS_LSB+:3] == btp_pkg::CKS_EXT) begin
        own_edge[i] = run[i] & xc_edge[i]; // [R2]
      end else begin
        own_edge[i] = run[i] & tick[ctrl_q[i][btp_pkg::CKS_LSB+:3]]; // [R1]
      end
    end
    for (int u = 0; u < btp_pkg::N_UNIT; u++) begin
      cs = ctrl_q[2*u+1][btp_pkg::CASC_LSB+:2];
      m8a = own_edge[2*u] & (cnt_q[2*u] == cmpa_q[2*u]); // [R18]
      m8b = own_edge[2*u] & (cnt_q[2*u] == cmpb_q[2*u]);
      // odd channel: own clock, or the even channel's matches
      edge_c[2*u+1] = (cs == btp_pkg::CASC_CMC) ? (run[2*u+1] & (m8a | m8b))
        : own_edge[2*u+1]; // [R8]
      ma[2*u+1] = edge_c[2*u+1] & (cnt_q[2*u+1] == cmpa_q[2*u+1]); // [R4] [R18]
      mb[2*u+1] = edge_c[2*u+1] & (cnt_q[2*u+1] == cmpb_q[2*u+1]);
      if (cs == btp_pkg::CASC_16) begin
        // one 16-bit counter, upper byte even, lower byte odd
        c16 = {cnt_q[2*u], cnt_q[2*u+1]}; // [R7]
        edge_c[2*u] = edge_c[2*u+1] & (cnt_q[2*u+1] == btp_pkg::CNT_MAX);
        ma[2*u] = edge_c[2*u+1] & (c16 == {cmpa_q[2*u], cmpa_q[2*u+1]}); // [R4]
        mb[2*u] = edge_c[2*u+1] & (c16 == {cmpb_q[2*u], cmpb_q[2*u+1]});
        clr[2*u] = clr_f(ctrl_q[2*u][btp_pkg::CLR_LSB+:2], ma[2*u], mb[2*u],
          xr_edge[2*u]);
        clr[2*u+1] = clr[2*u];
        ovf[2*u] = edge_c[2*u] & (cnt_q[2*u] == btp_pkg::CNT_MAX) & ~clr[2*u]; // [R17]
      end else begin
        edge_c[2*u] = own_edge[2*u];
        ma[2*u] = m8a;
        mb[2*u] = m8b;
        clr[2*u] = clr_f(ctrl_q[2*u][btp_pkg::CLR_LSB+:2], m8a, m8b, xr_edge[2*u]);
        clr[2*u+1] = clr_f(ctrl_q[2*u+1][btp_pkg::CLR_LSB+:2], ma[2*u+1],
          mb[2*u+1], xr_edge[2*u+1]);
        ovf[2*u] = edge_c[2*u] & (cnt_q[2*u] == btp_pkg::CNT_MAX) & ~clr[2*u]; // [R17]
      end
      ovf[2*u+1] = edge_c[2*u+1] & (cnt_q[2*u+1] == btp_pkg::CNT_MAX) & ~clr[2*u+1];
    end
  end

  // software write wins over counting so a preset value is never lost
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < btp_pkg::N_CH; i++) begin
        cnt_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < btp_pkg::N_CH; i++) begin
        if (wr_en && in_ch && ch_sel == i && paddr[3:0] == btp_pkg::OFS_CNT) begin
          cnt_q[i] <= pwdata[7:0];
        end else if (clr[i] || evt_rst[i]) begin
          cnt_q[i] <= 8'h00; // [R5] [R11]
        end else if (edge_c[i]) begin
          cnt_q[i] <= cnt_q[i] + 8'h01; // [R3] [R17]
        end
      end
    end
  end

  // ------------------------------------------------------------
  // event, request and pin outputs
  // ------------------------------------------------------------
  // all requests are one-cycle pulses, one clock after the match
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_cma <= 4'h0;
      irq_cmb <= 4'h0;
      irq_ovf <= 4'h0;
      evt_cma <= 4'h0;
      evt_cmb <= 4'h0;
      evt_ovf <= 4'h0;
      dtc_req <= 4'h0;
      adc_trig <= 2'h0;
    end else begin
      irq_cma <= ma; // [R9]
      irq_cmb <= mb;
      irq_ovf <= ovf;
      evt_cma <= ma; // [R10]
      evt_cmb <= mb;
      evt_ovf <= ovf;
      dtc_req <= ma | mb; // [R12]
      adc_trig <= {ma[2], ma[0]}; // [R13]
    end
  end

  // baud clocks toggle on match A, so a serial clock is half the match rate
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      baud_clk <= 3'h0;
    end else begin
      baud_clk <= baud_clk ^ {ma[btp_pkg::BAUD12_CH], ma[btp_pkg::BAUD6_CH],
        ma[btp_pkg::BAUD5_CH]}; // [R14]
    end
  end

  // pwm: high on match A, low on match B; A wins if both land together
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tmo <= 4'h0;
    end else begin
      for (int i = 0; i < btp_pkg::N_CH; i++) begin
        unique case (ctrl_q[i][btp_pkg::OUT_LSB+:2])
          btp_pkg::OUT_TGL_A: tmo[i] <= tmo[i] ^ ma[i]; // [R6]
          btp_pkg::OUT_PWM: tmo[i] <= ma[i] | (tmo[i] & ~mb[i]); // [R6]
          btp_pkg::OUT_TGL_B: tmo[i] <= tmo[i] ^ mb[i];
          default: tmo[i] <= 1'b0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // decode and read mux; unaligned or unmapped addresses answer pslverr
  always_comb begin
    ch_sel = paddr[5:4];
    in_ch = paddr < btp_pkg::OFS_START;
    hit = (paddr[1:0] == 2'h0)
      && (in_ch || paddr == btp_pkg::OFS_START || paddr == btp_pkg::OFS_STOP);
    wr_en = psel & penable & pready & pwrite & hit;
    rdata = 32'h0000_0000;
    if (in_ch) begin
      unique case (paddr[3:0])
        btp_pkg::OFS_CTRL: rdata[btp_pkg::CTRL_W-1:0] = ctrl_q[ch_sel];
        btp_pkg::OFS_CMPA: rdata[7:0] = cmpa_q[ch_sel];
        btp_pkg::OFS_CMPB: rdata[7:0] = cmpb_q[ch_sel];
        btp_pkg::OFS_CNT: rdata[7:0] = cnt_q[ch_sel];
        default: rdata = 32'h0000_0000;
      endcase
    end else if (paddr == btp_pkg::OFS_START) begin
      rdata[3:0] = start_q;
    end else if (paddr == btp_pkg::OFS_STOP) begin
      rdata[1:0] = stop_q;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel && penable && !pready) begin
        prdata <= rdata;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < btp_pkg::N_CH; i++) begin
        ctrl_q[i] <= btp_pkg::RST_CTRL;
        cmpa_q[i] <= btp_pkg::RST_CMP;
        cmpb_q[i] <= btp_pkg::RST_CMP;
      end
      stop_q <= 2'h0;
    end else begin
      for (int i = 0; i < btp_pkg::N_CH; i++) begin
        if (wr_en && in_ch && ch_sel == i) begin
          if (paddr[3:0] == btp_pkg::OFS_CTRL) begin
            ctrl_q[i] <= pwdata[btp_pkg::CTRL_W-1:0];
          end
          if (paddr[3:0] == btp_pkg::OFS_CMPA) begin
            cmpa_q[i] <= pwdata[7:0];
          end
          if (paddr[3:0] == btp_pkg::OFS_CMPB) begin
            cmpb_q[i] <= pwdata[7:0];
          end
        end
      end
      if (wr_en && paddr == btp_pkg::OFS_STOP) begin
        stop_q <= pwdata[1:0]; // [R15]
      end
    end
  end

  // start bits: an event that sets a bit beats a software clear
  always_comb begin
    start_d = start_q;
    if (wr_en && paddr == btp_pkg::OFS_START) begin
      start_d = pwdata[3:0]; // [R16]
    end
    start_d = start_d | evt_set; // [R11]
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_q <= 4'h0;
    end else begin
      start_q <= start_d;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  div_two_tick_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R1]
    tick[1] |=> !tick[1]) else $error("divide-by-two tick not alternating");
  count_step_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R17]
    edge_c[0] && !clr[0] && !evt_rst[0] && !wr_en |=> cnt_q[0] == $past(cnt_q[0]) + 8'h01)
    else $error("counter did not step by one");
  ovf_wrap_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R17]
    ovf[1] && !wr_en |=> cnt_q[1] == 8'h00 && irq_ovf[1] ##1 !irq_ovf[1])
    else $error("overflow without wrap to zero");
  clear_on_a_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R5]
    ma[2] && ctrl_q[2][btp_pkg::CLR_LSB+:2] == btp_pkg::CLR_A && !wr_en
    |=> cnt_q[2] == 8'h00) else $error("match A did not clear counter");
  cmc_count_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R8]
    ctrl_q[1][btp_pkg::CASC_LSB+:2] == btp_pkg::CASC_CMC && run[1] && (ma[0] || mb[0])
    && !clr[1] && !evt_rst[1] && !wr_en |=> cnt_q[1] == $past(cnt_q[1]) + 8'h01)
    else $error("odd channel missed even match");
  irq_evt_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R9]
    ma[3] |=> irq_cma[3] && evt_cma[3] && dtc_req[3]) else $error("match A not reported");
  adc_trig_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R13]
    adc_trig == {$past(ma[2]), $past(ma[0])}) else $error("adc trigger wrong");
  unit_stop_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R15]
    stop_q[1] |-> edge_c[3:2] == 2'h0) else $error("stopped unit still counting");
  evt_start_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R11]
    evt_in[0] && ctrl_q[0][btp_pkg::EVT_LSB+:2] == btp_pkg::EVT_START |=> start_q[0])
    else $error("start event lost");
  apb_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R16]
    psel && penable && !pready |=> pready ##1 !pready) else $error("apb answer timing");
endmodule : btp_byte_timer

// File: verif/test_btp_byte_timer.sv
`timescale 1ns/1ns
module test_btp_byte_timer;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [btp_pkg::ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] ext_clk = 4'h0;
  logic [3:0] ext_rst = 4'h0;
  logic [3:0] evt_in = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [3:0] tmo, irq_cma, irq_cmb, irq_ovf, evt_cma, evt_cmb, evt_ovf, dtc_req;
  logic [1:0] adc_trig;
  logic [2:0] baud_clk;
  logic [32:0] exp_q[$];
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int seed;

  btp_byte_timer DUT (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ext_clk(ext_clk), .ext_rst(ext_rst),
    .evt_in(evt_in), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tmo(tmo),
    .irq_cma(irq_cma), .irq_cmb(irq_cmb), .irq_ovf(irq_ovf), .evt_cma(evt_cma),
    .evt_cmb(evt_cmb), .evt_ovf(evt_ovf), .dtc_req(dtc_req), .adc_trig(adc_trig),
    .baud_clk(baud_clk));

  // 20 MHz clock and a cycle count for period checks
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // reads pop the oldest note; sampled at the edge where pready is seen
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("read note", 32'h1, 32'h0);
      end else begin
        chk("pslverr", 32'(exp_q[0][32]), 32'(pslverr));
        chk("prdata", exp_q[0][31:0], prdata);
        void'(exp_q.pop_front());
      end
    end
  end

  // event, transfer and converter outputs mirror the interrupt pulses
  always @(negedge clk_sys) begin
    if ({evt_cma, evt_cmb, evt_ovf} !== {irq_cma, irq_cmb, irq_ovf}) begin
      chk("event link", {irq_cma, irq_cmb, irq_ovf}, {evt_cma, evt_cmb, evt_ovf});
    end
    if (dtc_req !== (irq_cma | irq_cmb)) begin
      chk("dtc_req", irq_cma | irq_cmb, dtc_req);
    end
    if (adc_trig !== {irq_cma[2], irq_cma[0]}) begin
      chk("adc_trig", {irq_cma[2], irq_cma[0]}, adc_trig);
    end
  end

  // ------------------------------------------------------------
  // bus and stimulus tasks
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready wait", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic e, input logic [31:0] d);
    exp_q.push_back({e, d});
    apb(1'b0, a, 32'h0);
  endtask : rd

  function automatic logic [7:0] ra(input int c, input logic [3:0] o);
    ra = {2'b00, 2'(c), o};
  endfunction : ra

  function automatic logic [31:0] ctl(input logic [2:0] k, input logic [1:0] c,
      input logic [1:0] o, input logic [1:0] e, input logic [1:0] s);
    ctl = 32'h0;
    ctl[btp_pkg::CKS_LSB +: 3] = k;
    ctl[btp_pkg::CLR_LSB +: 2] = c;
    ctl[btp_pkg::OUT_LSB +: 2] = o;
    ctl[btp_pkg::EVT_LSB +: 2] = e;
    ctl[btp_pkg::CASC_LSB +: 2] = s;
  endfunction : ctl

  // waits for the next match A (k=0) or overflow (k=1) pulse of a channel;
  // skips the pulse of the edge that just ended a register write (old setup)
  task automatic hit(input int ch, input int k, output int t);
    int n;
    n = 0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    while ((k ? irq_ovf[ch] : irq_cma[ch]) !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20000) chk("pulse wait", 32'h1, 32'h0);
    t = cyc;
  endtask : hit

  // period between two pulses; with tg set the timer output must flip
  task automatic per(input int ch, input int k, input int e, input logic tg);
    int t0, t1;
    logic o0;
    hit(ch, k, t0);
    o0 = tmo[ch];
    hit(ch, k, t1);
    chk("period", 32'(e), 32'(t1 - t0));
    if (tg) chk("tmo toggle", 32'(!o0), 32'(tmo[ch]));
  endtask : per

  // a halted channel must stay silent; the write edge itself may still pulse
  task automatic quiet(input int ch);
    int n;
    n = 0;
    @(posedge clk_sys);
    repeat (40) begin
      @(negedge clk_sys);
      if (irq_cma[ch] !== 1'b0) n++;
    end
    chk("halted pulses", 32'h0, 32'(n));
  endtask : quiet

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int dv[7] = '{1, 2, 8, 32, 64, 1024, 8192};
    int t;
    logic [31:0] v;
    logic b0;
    seed = 32'h23ef607d;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd(ra(c, btp_pkg::OFS_CTRL), 1'b0, 32'(btp_pkg::RST_CTRL));
      rd(ra(c, btp_pkg::OFS_CMPA), 1'b0, {24'h0, btp_pkg::RST_CMP});
      v = $random(seed);
      wr(ra(c, btp_pkg::OFS_CMPB), v);
      rd(ra(c, btp_pkg::OFS_CMPB), 1'b0, {24'h0, v[7:0]});
    end
    rd(btp_pkg::OFS_START, 1'b0, 32'h0);
    rd(btp_pkg::OFS_STOP, 1'b0, 32'h0);
    rd(8'h48, 1'b1, 32'h0);
    rd(8'h06, 1'b1, 32'h0);
    // every internal divider, channel 0 clearing on match A at 1
    wr(ra(0, btp_pkg::OFS_CMPA), 32'h1);
    wr(btp_pkg::OFS_START, 32'h1);
    for (int k = 0; k < 7; k++) begin
      wr(ra(0, btp_pkg::OFS_CTRL), ctl(3'(k), btp_pkg::CLR_A, btp_pkg::OUT_TGL_A, 2'h0, 2'h0));
      per(0, 0, 2 * dv[k], 1'b1);
    end
    wr(ra(0, btp_pkg::OFS_CTRL), ctl(3'h0, btp_pkg::CLR_A, btp_pkg::OUT_TGL_A, 2'h0, 2'h0));
    wr(btp_pkg::OFS_STOP, 32'h1);
    quiet(0);
    wr(btp_pkg::OFS_STOP, 32'h0);
    per(0, 0, 2, 1'b1);
    wr(btp_pkg::OFS_START, 32'h0);
    quiet(0);
    // free-running lower channel: overflow every 256 counts, baud toggles
    wr(ra(1, btp_pkg::OFS_CTRL), 32'h0);
    wr(btp_pkg::OFS_START, 32'h2);
    per(1, 1, 256, 1'b0);
    hit(1, 0, t);
    b0 = baud_clk[0];
    hit(1, 0, t);
    chk("baud toggle", 32'(!b0), 32'(baud_clk[0]));
    // cascaded pair: 16-bit match at 0x0102 gives a 259-cycle period
    wr(btp_pkg::OFS_START, 32'h0);
    wr(ra(0, btp_pkg::OFS_CNT), 32'h0);
    wr(ra(1, btp_pkg::OFS_CNT), 32'h0);
    wr(ra(0, btp_pkg::OFS_CMPA), 32'h1);
    wr(ra(1, btp_pkg::OFS_CMPA), 32'h2);
    wr(ra(1, btp_pkg::OFS_CTRL), ctl(3'h0, 2'h0, 2'h0, 2'h0, btp_pkg::CASC_16));
    wr(btp_pkg::OFS_START, 32'h3);
    per(0, 0, 259, 1'b1);
    // compare match count: lower channel counts upper matches (every 2 cycles)
    // upper match B parked out of reach so only match A clocks the lower channel
    wr(ra(0, btp_pkg::OFS_CMPB), 32'hFF);
    wr(ra(1, btp_pkg::OFS_CMPA), 32'h3);
    wr(ra(1, btp_pkg::OFS_CTRL), ctl(3'h0, btp_pkg::CLR_A, 2'h0, 2'h0, btp_pkg::CASC_CMC));
    per(1, 0, 8, 1'b0);
    // event start on channel 2
    wr(ra(2, btp_pkg::OFS_CMPA), 32'h2);
    wr(ra(2, btp_pkg::OFS_CTRL), ctl(3'h0, btp_pkg::CLR_A, 2'h0, btp_pkg::EVT_START, 2'h0));
    quiet(2);
    @(posedge clk_sys);
    evt_in[2] <= 1'b1;
    @(posedge clk_sys);
    evt_in[2] <= 1'b0;
    per(2, 0, 3, 1'b0);
    b0 = baud_clk[2];
    hit(2, 0, t);
    chk("baud twelve", 32'(!b0), 32'(baud_clk[2]));
    // events counted as clock on channel 3
    wr(ra(3, btp_pkg::OFS_CTRL), ctl(btp_pkg::CKS_EXT, 2'h0, 2'h0, btp_pkg::EVT_COUNT, 2'h0));
    wr(ra(3, btp_pkg::OFS_CNT), 32'h0);
    wr(btp_pkg::OFS_START, 32'h8);
    v = 32'(1 + ($random(seed) & 3));
    repeat (v) begin
      @(posedge clk_sys);
      evt_in[3] <= 1'b1;
      @(posedge clk_sys);
      evt_in[3] <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    rd(ra(3, btp_pkg::OFS_CNT), 1'b0, v);
    // restart event: clears and sets the start bit
    wr(ra(3, btp_pkg::OFS_CTRL), ctl(btp_pkg::CKS_EXT, btp_pkg::CLR_EXT, 2'h0,
      btp_pkg::EVT_RESTART, 2'h0));
    wr(btp_pkg::OFS_START, 32'h0);
    @(posedge clk_sys);
    evt_in[3] <= 1'b1;
    @(posedge clk_sys);
    evt_in[3] <= 1'b0;
    rd(ra(3, btp_pkg::OFS_CNT), 1'b0, 32'h0);
    rd(btp_pkg::OFS_START, 1'b0, 32'h8);
    // external clock edges, then external reset
    repeat (v) begin
      repeat (4) @(posedge clk_sys);
      ext_clk[3] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_clk[3] <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    rd(ra(3, btp_pkg::OFS_CNT), 1'b0, v);
    ext_rst[3] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ext_rst[3] <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(ra(3, btp_pkg::OFS_CNT), 1'b0, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk("notes left", 32'h0, 32'(exp_q.size()));
    end_of_test();
  end

  // watchdog: the whole run needs about 35000 cycles, the slowest divider most
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end
endmodule : test_btp_byte_timer
